// ---- verilog/cfa_pkg.sv ----
package cfa_pkg;

  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int unsigned CFA_SECTORS      = 8;
  localparam int unsigned CFA_SECTOR_BYTES = 256;
  localparam int unsigned CFA_PAGE_BYTES   = 16;
  localparam int unsigned CFA_CODE_BYTES   = CFA_SECTORS * CFA_SECTOR_BYTES;
  localparam int unsigned CFA_ADDR_W       = 11;
  localparam int unsigned CFA_SEC_W        = 3;
  localparam int unsigned CFA_PAGE_LSB     = 4;
  localparam int unsigned CFA_SEC_LSB      = 8;

  // ---------------------------------------------------------------
  // Reset values and constants
  // ---------------------------------------------------------------
  localparam logic [7:0]  CFA_ERASED_BYTE = 8'hff;
  localparam logic [31:0] CFA_CRC_INIT    = 32'hffffffff;
  localparam logic [31:0] CFA_CRC_POLY    = 32'hedb88320;
  localparam logic [7:0]  CFA_SEC_OPEN    = 8'h00;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CFA_CLK_HZ     = 10_000_000;
  localparam int unsigned CFA_OP_TIME_US = 2000;
  // Longest time rounds down; leave 1/4 margin for the sweep itself
  localparam int unsigned CFA_OP_CYCLES  = (CFA_OP_TIME_US * (CFA_CLK_HZ / 1_000_000)) * 3 / 4;

  // ---------------------------------------------------------------
  // Commands and states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    CFA_CMD_LOAD    = 3'h0,
    CFA_CMD_PROGRAM = 3'h1,
    CFA_CMD_ERASE_B = 3'h2,
    CFA_CMD_ERASE_P = 3'h3,
    CFA_CMD_ERASE_S = 3'h4,
    CFA_CMD_CRC_S   = 3'h5,
    CFA_CMD_CRC_ALL = 3'h6,
    CFA_CMD_SECURE  = 3'h7
  } cfa_cmd_type;

  typedef enum logic [2:0] {
    CFA_ST_IDLE  = 3'b000,
    CFA_ST_SWEEP = 3'b001,
    CFA_ST_WAIT  = 3'b011,
    CFA_ST_DONE  = 3'b010
  } cfa_state_type;

endpackage

// ---- verilog/cfa_array.sv ----
`timescale 1ns/10ps
// Code flash cell array, one byte port, registered read data
module cfa_array
  import cfa_pkg::*;
(
  input  wire logic                  clock,   // System clock
  input  wire logic [CFA_ADDR_W-1:0] addr,    // Byte address
  input  wire logic                  wr_en,   // Write strobe
  input  wire logic [7:0]            wr_data, // Byte to store
  output      logic [7:0]            rd_data  // Registered read byte
);
  logic [7:0] mem [CFA_CODE_BYTES];

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  // No reset: the array holds its contents like a real cell field
  always_ff @(posedge clock)
  begin
    if (wr_en)
    begin
      mem[addr] <= wr_data;
    end
    rd_data <= mem[addr];
  end
endmodule // cfa_array

// ---- verilog/cfa_ctrl.sv ----
`timescale 1ns/10ps
// Contract
// [R1] Eight sectors of 256 bytes, 2048-byte byte-addressed code space.
// [R2] Sixteen-byte pages, boundary at every 16-byte-aligned address.
// [R3] Erase a byte, a 16-byte page or a 256-byte sector.
// [R4] Sixteen-byte page buffer loads 1 to 16 bytes, programmed at once.
// [R5] Code-space reads of secured sectors refused; unsecured reads allowed.
// [R6] Requests accepted from firmware path and from external serial programmer.
// [R7] No readout to programmer; 32-bit CRC over one sector or whole space.
// [R8] Eight security bytes, each protecting only its own sector.
// [R9] Every program or erase finishes within 2 ms, timed internally.
// [R10] Busy during operations, new requests rejected, completion signalled.
module cfa_ctrl
  import cfa_pkg::*;
(
  input  wire logic                          clock,       // System clock, 10 MHz
  input  wire logic                          arst_n,      // Async reset, active low
  input  wire logic                          iap_req,     // Firmware path request pulse
  input  wire cfa_pkg::cfa_cmd_type          iap_cmd,     // Firmware command
  input  wire logic [cfa_pkg::CFA_ADDR_W-1:0] iap_addr,   // Firmware address
  input  wire logic [7:0]                    iap_data,    // Firmware data / security byte
  input  wire logic                          icp_req,     // Programmer path request pulse
  input  wire cfa_pkg::cfa_cmd_type          icp_cmd,     // Programmer command
  input  wire logic [cfa_pkg::CFA_ADDR_W-1:0] icp_addr,   // Programmer address
  input  wire logic [7:0]                    icp_data,    // Programmer data
  input  wire logic                          rd_req,      // Code-space read request
  input  wire logic [cfa_pkg::CFA_ADDR_W-1:0] rd_addr,    // Code-space read address
  output logic                               rd_valid,    // Read answer pulse
  output logic                               rd_denied,   // Read refused, secured sector or array port busy
  output logic [7:0]                         rd_data,     // Read byte
  output logic                               busy,        // Operation in progress
  output logic                               done,        // Completion pulse
  output logic                               rejected,    // Request refused pulse
  output logic [31:0]                        crc,         // Last CRC result
  output logic                               crc_valid    // CRC result pulse
);
  import cfa_pkg::*;

  typedef struct packed {
    cfa_state_type                 st;
    cfa_cmd_type                   cmd;
    logic [CFA_ADDR_W-1:0]         base;
    logic [CFA_ADDR_W-1:0]         cnt;
    logic [CFA_ADDR_W-1:0]         last;
    logic [20:0]                   timer;
    logic [CFA_PAGE_BYTES-1:0]     pb_valid;
    logic [CFA_PAGE_BYTES*8-1:0]   pb_data;
    logic [CFA_ADDR_W-1:CFA_PAGE_LSB] pb_page;
    logic [CFA_SECTORS*8-1:0]      sec;
    logic [31:0]                   crc_acc;
    logic                          sweep_rd;
    logic                          rd_valid;
    logic                          rd_denied;
    logic                          busy;
    logic                          done;
    logic                          rejected;
    logic [31:0]                   crc;
    logic                          crc_valid;
  } cfa_state_regs_type;

  cfa_state_regs_type s_r;
  cfa_state_regs_type s_nxt;

  logic [CFA_ADDR_W-1:0] arr_addr;
  logic                  arr_wr;
  logic [7:0]            arr_wdata;
  logic [7:0]            arr_rdata;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Sector index of a byte address
  function automatic logic [CFA_SEC_W-1:0] sec_of(input logic [CFA_ADDR_W-1:0] a);
    return a[CFA_ADDR_W-1:CFA_SEC_LSB];
  endfunction

  // CRC commands read the array instead of writing it
  function automatic logic is_crc(input cfa_cmd_type c);
    return (c == CFA_CMD_CRC_S) || (c == CFA_CMD_CRC_ALL);
  endfunction

  // One CRC-32 byte step, reflected polynomial
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] x;
    x = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++)
    begin
      x = x[0] ? ((x >> 1) ^ CFA_CRC_POLY) : (x >> 1);
    end
    return x;
  endfunction

  logic                  req_any;
  cfa_cmd_type           req_cmd;
  logic [CFA_ADDR_W-1:0] req_addr;
  logic [7:0]            req_data;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    s_nxt     = s_r;
    arr_addr  = s_r.cnt;
    arr_wr    = 1'b0;
    arr_wdata = CFA_ERASED_BYTE;
    // Firmware path has priority when both arrive together
    req_any  = iap_req | icp_req;                                      // see [R6]
    req_cmd  = iap_req ? iap_cmd : icp_cmd;
    req_addr = iap_req ? iap_addr : icp_addr;
    req_data = iap_req ? iap_data : icp_data;
    s_nxt.done      = 1'b0;
    s_nxt.rejected  = 1'b0;
    s_nxt.crc_valid = 1'b0;
    s_nxt.rd_valid  = 1'b0;
    s_nxt.rd_denied = 1'b0;
    s_nxt.sweep_rd  = 1'b0;
    // A running operation owns the array; late requests are only refused
    if (s_r.st != CFA_ST_IDLE && req_any)
    begin
      s_nxt.rejected = 1'b1;                                           // see [R10]
    end

    // Code-space reads only while the array port is free
    if (rd_req)
    begin
      if (s_r.st != CFA_ST_IDLE || req_any || s_r.sec[sec_of(rd_addr)*8 +: 8] != CFA_SEC_OPEN) // see [R5] [R8]
      begin
        s_nxt.rd_denied = 1'b1;                                        // see [R10]
      end
      else
      begin
        // Answer flags the same edge that registers the array byte
        arr_addr       = rd_addr;                                      // see [R1]
        s_nxt.rd_valid = 1'b1;
      end
    end

    case (s_r.st)
      CFA_ST_IDLE:
      begin
        if (req_any)
        begin
          s_nxt.cmd      = req_cmd;
          s_nxt.timer    = '0;
          case (req_cmd)
            CFA_CMD_LOAD:
            begin
              // A load into another page restarts the buffer
              if (req_addr[CFA_ADDR_W-1:CFA_PAGE_LSB] != s_r.pb_page)  // see [R4]
              begin
                s_nxt.pb_valid = '0;
              end
              s_nxt.pb_page = req_addr[CFA_ADDR_W-1:CFA_PAGE_LSB];
              s_nxt.pb_valid[req_addr[CFA_PAGE_LSB-1:0]] = 1'b1;
              s_nxt.pb_data[req_addr[CFA_PAGE_LSB-1:0]*8 +: 8] = req_data;
              s_nxt.done = 1'b1;
            end
            CFA_CMD_SECURE:
            begin
              s_nxt.sec[sec_of(req_addr)*8 +: 8] = req_data;          // see [R8]
              s_nxt.done = 1'b1;
            end
            CFA_CMD_PROGRAM:
            begin
              s_nxt.base = {s_r.pb_page, 4'h0};                       // see [R2]
              s_nxt.last = {s_r.pb_page, 4'hf};
              s_nxt.st   = CFA_ST_SWEEP;
            end
            CFA_CMD_ERASE_B:
            begin
              s_nxt.base = req_addr;                                   // see [R3]
              s_nxt.last = req_addr;
              s_nxt.st   = CFA_ST_SWEEP;
            end
            CFA_CMD_ERASE_P:
            begin
              s_nxt.base = {req_addr[CFA_ADDR_W-1:CFA_PAGE_LSB], 4'h0}; // see [R3] [R2]
              s_nxt.last = {req_addr[CFA_ADDR_W-1:CFA_PAGE_LSB], 4'hf};
              s_nxt.st   = CFA_ST_SWEEP;
            end
            CFA_CMD_ERASE_S, CFA_CMD_CRC_S:
            begin
              s_nxt.base = {sec_of(req_addr), 8'h00};                  // see [R3] [R7]
              s_nxt.last = {sec_of(req_addr), 8'hff};
              s_nxt.st   = CFA_ST_SWEEP;
            end
            CFA_CMD_CRC_ALL:
            begin
              s_nxt.base = '0;                                         // see [R7]
              s_nxt.last = '1;
              s_nxt.st   = CFA_ST_SWEEP;
            end
            default:
            begin
              s_nxt.rejected = 1'b1;
            end
          endcase
          s_nxt.cnt     = s_nxt.base;
          s_nxt.crc_acc = CFA_CRC_INIT;
          s_nxt.busy    = (s_nxt.st != CFA_ST_IDLE);                   // see [R10]
        end
      end
      CFA_ST_SWEEP:
      begin
        s_nxt.timer = s_r.timer + 21'd1;
        if (is_crc(s_r.cmd))
        begin
          // Array read is one cycle late; fold the previous byte in
          s_nxt.sweep_rd = 1'b1;
          if (s_r.sweep_rd)
          begin
            s_nxt.crc_acc = crc_step(s_r.crc_acc, arr_rdata);         // see [R7]
          end
        end
        else if (s_r.cmd == CFA_CMD_PROGRAM)
        begin
          // Only loaded bytes are written; others keep their contents
          arr_wr    = s_r.pb_valid[s_r.cnt[CFA_PAGE_LSB-1:0]];        // see [R4]
          arr_wdata = s_r.pb_data[s_r.cnt[CFA_PAGE_LSB-1:0]*8 +: 8];
        end
        else
        begin
          arr_wr = 1'b1;
        end
        if (s_r.cnt == s_r.last)
        begin
          s_nxt.st = CFA_ST_WAIT;
        end
        else
        begin
          s_nxt.cnt = s_r.cnt + 11'd1;
        end
      end
      CFA_ST_WAIT:
      begin
        s_nxt.timer = s_r.timer + 21'd1;
        // CRC folds its last byte; program and erase sit out the timer
        if (is_crc(s_r.cmd))
        begin
          s_nxt.crc_acc = crc_step(s_r.crc_acc, arr_rdata);
          s_nxt.st      = CFA_ST_DONE;
        end
        else if (s_r.timer >= 21'(CFA_OP_CYCLES - 1))                  // see [R9]
        begin
          s_nxt.st = CFA_ST_DONE;
        end
      end
      CFA_ST_DONE:
      begin
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;                                             // see [R10]
        s_nxt.st   = CFA_ST_IDLE;
        if (is_crc(s_r.cmd))
        begin
          s_nxt.crc       = ~s_r.crc_acc;
          s_nxt.crc_valid = 1'b1;
        end
        if (s_r.cmd == CFA_CMD_PROGRAM)
        begin
          s_nxt.pb_valid = '0;
        end
      end
      default:
      begin
        s_nxt.st   = CFA_ST_IDLE;
        s_nxt.busy = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_r       <= '0;
      s_r.st    <= CFA_ST_IDLE;
      s_r.crc_acc <= CFA_CRC_INIT;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Cell array
  // ---------------------------------------------------------------
  cfa_array u_array (
    .clock   (clock),
    .addr    (arr_addr),
    .wr_en   (arr_wr),
    .wr_data (arr_wdata),
    .rd_data (arr_rdata)
  );

  // Read data is the array's own register; other outputs from s_r
  assign rd_valid  = s_r.rd_valid;
  assign rd_denied = s_r.rd_denied;
  assign rd_data   = arr_rdata;
  assign busy      = s_r.busy;
  assign done      = s_r.done;
  assign rejected  = s_r.rejected;
  assign crc       = s_r.crc;
  assign crc_valid = s_r.crc_valid;
endmodule // cfa_ctrl

// ---- verification/cfa_ctrl_chk.sv ----
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Port checker for the flash access controller
// ---------------------------------------------------------------
module cfa_ctrl_chk
  import cfa_pkg::*;
(
  input wire logic                 clock,     // System clock
  input wire logic                 arst_n,    // Async reset, active low
  input wire logic                 iap_req,   // Firmware request
  input wire cfa_pkg::cfa_cmd_type iap_cmd,   // Firmware command
  input wire logic                 icp_req,   // Programmer request
  input wire cfa_pkg::cfa_cmd_type icp_cmd,   // Programmer command
  input wire logic                 rd_req,    // Read request
  input wire logic                 rd_valid,  // Read answer
  input wire logic                 rd_denied, // Read refused
  input wire logic                 busy,      // Operation running
  input wire logic                 done,      // Completion pulse
  input wire logic                 rejected,  // Refused request
  input wire logic [31:0]          crc,       // CRC result
  input wire logic                 crc_valid  // CRC pulse
);
  logic [15:0] bcnt_r; // Cycles spent busy

  // Busy length, saturating so a stuck busy cannot wrap back under the limit
  always_ff @(posedge clock or negedge arst_n)
    if (!arst_n)
      bcnt_r <= 16'h0000;
    else if (!busy)
      bcnt_r <= 16'h0000;
    else if (bcnt_r != 16'hffff)
      bcnt_r <= bcnt_r + 16'h0001;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  a_busy_bounded: assert property (bcnt_r < 16'h4e20)
    else $error("operation longer than 2 ms");
  a_fall_done: assert property ($fell(busy) |-> done)
    else $error("busy ended without done");
  a_reject_busy: assert property (busy && (iap_req || icp_req) |=> rejected)
    else $error("request while busy not rejected");
  a_reject_cause: assert property (rejected |-> $past(iap_req) || $past(icp_req))
    else $error("reject without request");
  a_load_done: assert property (!busy && !done && iap_req && iap_cmd == CFA_CMD_LOAD |=> done && !busy)
    else $error("buffer load not completed at once");
  a_start_busy: assert property (!busy && !done && iap_req &&
    iap_cmd inside {CFA_CMD_PROGRAM, CFA_CMD_ERASE_B, CFA_CMD_ERASE_P, CFA_CMD_ERASE_S} |=> busy [*2])
    else $error("flash operation did not hold busy");
  a_icp_start: assert property (!busy && !done && !iap_req && icp_req && icp_cmd == CFA_CMD_ERASE_S |=> busy)
    else $error("programmer request ignored");
  a_read_answer: assert property (rd_req |=> rd_valid != rd_denied)
    else $error("read not answered once");
  a_read_cause: assert property (rd_valid || rd_denied |-> $past(rd_req))
    else $error("read answer without request");
  a_crc_done: assert property (crc_valid |-> done)
    else $error("crc result without done");
  a_crc_hold: assert property (!crc_valid |-> $stable(crc))
    else $error("crc changed without result pulse");
  a_done_pulse: assert property (done && !(iap_req || icp_req) |=> !done)
    else $error("done longer than one cycle");
endmodule // cfa_ctrl_chk

bind cfa_ctrl cfa_ctrl_chk u_cfa_ctrl_chk (.clock, .arst_n, .iap_req, .iap_cmd, .icp_req, .icp_cmd, .rd_req,
  .rd_valid, .rd_denied, .busy, .done, .rejected, .crc, .crc_valid);

// ---- verification/cfa_host.sv ----
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Request source: firmware or external programmer
// ---------------------------------------------------------------
module cfa_host
  import cfa_pkg::*;
(
  input  wire logic                        clock, // System clock
  output logic                             req,   // Request pulse
  output cfa_pkg::cfa_cmd_type             cmd,   // Command
  output logic [cfa_pkg::CFA_ADDR_W-1:0]   addr,  // Address
  output logic [7:0]                       data   // Data
);
  // Idle lines at time zero
  initial
  begin
    req  = 1'b0;
    cmd  = CFA_CMD_LOAD;
    addr = 11'h000;
    data = 8'h00;
  end

  // One-cycle request; released address and data lines show the inverse, cmd keeps its last value
  task automatic issue(input cfa_cmd_type c, input logic [CFA_ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clock);
    req  <= 1'b1;
    cmd  <= c;
    addr <= a;
    data <= d;
    @(posedge clock);
    req  <= 1'b0;
    addr <= ~a;
    data <= ~d;
  endtask
endmodule // cfa_host

// ---- verification/test_code_flash_access_control.sv ----
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Self-checking bench for the flash access controller
// ---------------------------------------------------------------
module test_code_flash_access_control;
  import cfa_pkg::*;
  logic        clock, arst_n, iap_req, icp_req, rd_req, rd_valid, rd_denied, busy, done, rejected, crc_valid;
  cfa_cmd_type iap_cmd, icp_cmd;
  logic [10:0] iap_addr, icp_addr, rd_addr;
  logic [7:0]  iap_data, icp_data, rd_data, v;
  logic [31:0] crc;
  logic        den, cv, vld;
  int          mismatches = 0, n_tests = 0, cycles = 0, n;

  cfa_ctrl u_cfa_ctrl (.clock(clock), .arst_n(arst_n), .iap_req(iap_req), .iap_cmd(iap_cmd),
    .iap_addr(iap_addr), .iap_data(iap_data), .icp_req(icp_req), .icp_cmd(icp_cmd), .icp_addr(icp_addr),
    .icp_data(icp_data), .rd_req(rd_req), .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_denied(rd_denied),
    .rd_data(rd_data), .busy(busy), .done(done), .rejected(rejected), .crc(crc), .crc_valid(crc_valid));
  cfa_host u_fw (.clock(clock), .req(iap_req), .cmd(iap_cmd), .addr(iap_addr), .data(iap_data));
  cfa_host u_prog (.clock(clock), .req(icp_req), .cmd(icp_cmd), .addr(icp_addr), .data(icp_data));

  // Clock, 100 ns period
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("comparisons=%0d mismatches=%0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Bounded wait for the done pulse, sampled after the edge settles
  task automatic wait_done;
    n = 0;
    do
    begin
      @(posedge clock);
      #1;
      n++;
    end while (done !== 1'b1 && n < 20000);
    cv = crc_valid;
  endtask

  // One code-space read; the answer stands in the cycle after the request edge
  task automatic rd(input logic [10:0] a);
    @(posedge clock);
    rd_req  <= 1'b1;
    rd_addr <= a;
    @(posedge clock);
    rd_req  <= 1'b0;
    rd_addr <= ~a;
    #1;
    v   = rd_data;
    den = rd_denied;
    vld = rd_valid;
  endtask

  // Reference CRC over n erased bytes, bit-serial reflected form
  function automatic logic [31:0] crc_ff(input int nb);
    logic [31:0] c;
    c = CFA_CRC_INIT;
    for (int i = 0; i < nb * 8; i++)
      c = c[0] ? c >> 1 : (c >> 1) ^ CFA_CRC_POLY;
    return ~c;
  endfunction

  task automatic t_reset;
    check(busy, 1'b0);
    check({done, rejected, crc_valid}, 3'h0);
    $display("test reset finished");
  endtask

  task automatic t_program;
    u_fw.issue(CFA_CMD_LOAD, 11'h012, 8'ha5);
    #1 check(done, 1'b1);
    u_fw.issue(CFA_CMD_LOAD, 11'h013, 8'h3c);
    #1 check(done, 1'b1);
    u_fw.issue(CFA_CMD_PROGRAM, 11'h010, 8'h00);
    #1 check(busy, 1'b1);
    wait_done;
    check(n < 20000, 1'b1);
    rd(11'h012);
    check({vld, den, v}, 10'h2a5);
    rd(11'h013);
    check(v, 8'h3c);
    $display("test program finished");
  endtask

  task automatic t_erase_byte;
    u_prog.issue(CFA_CMD_ERASE_B, 11'h012, 8'h00);
    #1 check(busy, 1'b1);
    u_fw.issue(CFA_CMD_SECURE, 11'h100, 8'h5a);
    #1 check(rejected, 1'b1);
    rd(11'h013);
    check({vld, den}, 2'b01);
    wait_done;
    check(n < 20000, 1'b1);
    rd(11'h012);
    check(v, 8'hff);
    rd(11'h013);
    check(v, 8'h3c);
    rd(11'h100);
    check(den, 1'b0);
    $display("test erase byte finished");
  endtask

  task automatic t_secure;
    u_fw.issue(CFA_CMD_SECURE, 11'h100, 8'h5a);
    #1 check(done, 1'b1);
    rd(11'h105);
    check({vld, den}, 2'b01);
    rd(11'h1ff);
    check(den, 1'b1);
    rd(11'h200);
    check(den, 1'b0);
    rd(11'h013);
    check({den, v}, 9'h03c);
    $display("test security finished");
  endtask

  task automatic t_crc;
    u_prog.issue(CFA_CMD_ERASE_S, 11'h2a0, 8'h00);
    wait_done;
    check(n < 20000, 1'b1);
    rd(11'h2ff);
    check(v, 8'hff);
    u_prog.issue(CFA_CMD_CRC_S, 11'h2a0, 8'h00);
    wait_done;
    check(cv, 1'b1);
    check(n == CFA_SECTOR_BYTES + 2, 1'b1);
    check(crc, crc_ff(256));
    $display("test crc finished");
  endtask

  // Unaligned page address must still clear the whole page it falls in
  task automatic t_erase_page;
    u_fw.issue(CFA_CMD_ERASE_P, 11'h01c, 8'h00);
    #1 check(busy, 1'b1);
    wait_done;
    check(n < 20000, 1'b1);
    rd(11'h013);
    check({vld, v}, 9'h1ff);
    // Most of the array was never written, so only the sweep span is judged
    u_prog.issue(CFA_CMD_CRC_ALL, 11'h000, 8'h00);
    wait_done;
    check(cv, 1'b1);
    check(n == CFA_CODE_BYTES + 2, 1'b1);
    $display("test page erase and full crc finished");
  endtask

  // Hang guard: four long operations need about 60000 cycles
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      mismatches++;
      report_and_stop;
    end
  end

  initial
  begin
    rd_req  = 1'b0;
    rd_addr = 11'h000;
    arst_n  = 1'b0;
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    #1;
    t_reset;
    t_program;
    t_erase_byte;
    t_secure;
    t_crc;
    t_erase_page;
    report_and_stop;
  end
endmodule // test_code_flash_access_control
